// ---- core/umcl_pkg.sv ----
// Shared constants and types for the dual-channel modem control and loopback block.
// Assumes one 25 MHz clock, a synchronous active-high reset and a word-addressed register bus.
//
// Functional notes
// - Control bit 7 selects divide by four.
// - Each channel has its own prescaler.
// - Prescaler output drives the baud rate generator.
// - Control bit 6 selects infrared line encoding.
// - Infrared transmit output idles low.
// - Bit 5 lets any character but XOFF resume halted transmit.
// - Resuming character stored unless stop/start code.
// - Loopback drives serial output pin to marking.
// - Loopback feeds transmit shifter into receiver.
// - Loopback feeds modem inputs from control bits.
// - Loopback forces modem output pins high.
// - Loopback keeps data interrupts working, masked.
// - Loopback modem interrupts come from control bits.
// - Bit 3 set drives auxiliary output two low.
// - Shared pin: aux two, baud clock, DMA ready.
// - Loopback shows aux output one as ring.
// - Bits 1, 0 set drive request/terminal-ready low.
package umcl_pkg;

  localparam int UMCL_CHANNELS = 2;

  // Register word indices within a channel; channel select is address bit 3.
  localparam logic [2:0] REG_DATA = 3'h0;
  localparam logic [2:0] REG_MLC = 3'h1;
  localparam logic [2:0] REG_MSR = 3'h2;
  localparam logic [2:0] REG_DIV = 3'h3;
  localparam logic [2:0] REG_FLOW = 3'h4;
  localparam logic [2:0] REG_AFS = 3'h5;
  localparam logic [2:0] REG_IST = 3'h6;
  localparam logic [2:0] REG_IMK = 3'h7;

  // Field positions of modem_line_control.
  localparam int MLC_DIV4 = 7;
  localparam int MLC_IR = 6;
  localparam int MLC_XANY = 5;
  localparam int MLC_LOOP = 4;
  localparam int MLC_AUX_OUTPUT_TWO = 3;
  localparam int MLC_AUX_OUTPUT_ONE = 2;
  localparam int MLC_RTS = 1;
  localparam int MLC_DTR = 0;

  // Interrupt status and mask bit positions.
  localparam int IRQ_RX = 0;
  localparam int IRQ_TX = 1;
  localparam int IRQ_MS = 2;

  // Reset values.
  localparam logic [7:0] MLC_RESET = 8'h00;
  localparam logic [15:0] DIV_RESET = 16'h0001;
  localparam logic [7:0] XON_RESET = 8'h11;
  localparam logic [7:0] XOFF_RESET = 8'h13;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  // Timing counts.
  localparam int PRESCALE_SLOW = 4;
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
  localparam logic [3:0] MID_BIT = 4'h7;
  localparam logic [3:0] IR_PULSE_TICKS = 4'h3;

  typedef enum logic [1:0] {
    AFS_AUX_OUTPUT_TWO = 2'h0,
    AFS_BAUD = 2'h1,
    AFS_RXRDY = 2'h2
  } umcl_afs_t;

  typedef enum logic [3:0] {
    SH_IDLE = 4'h1,
    SH_START = 4'h2,
    SH_DATA = 4'h4,
    SH_STOP = 4'h8
  } umcl_shift_t;

  // Modem status, true sense; bit order matches the status register.
  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } umcl_mstat_t;

  typedef struct packed {
    logic rts;
    logic dtr;
  } umcl_mctl_t;

endpackage

// ---- core/umcl_baud_gen.sv ----
// Per-channel prescaler and baud rate generator producing a 16x tick.
// Assumes the divisor is stable between ticks; a divisor of zero acts as one.
`timescale 1ns/1ns
`default_nettype none
module umcl_baud_gen
  import umcl_pkg::*;
#(
  parameter int DIV_W = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic div_by_four,
  input wire logic [DIV_W-1:0] divisor,
  output logic tick16,
  output logic baud_clk
);

  generate
    if (DIV_W < 2 || DIV_W > 16) begin : g_bad_width
      $error("umcl_baud_gen: DIV_W must be 2 to 16");
    end
  endgenerate

  localparam logic [1:0] PRE_LAST = 2'(PRESCALE_SLOW - 1);

  logic [1:0] pre_r;
  logic [DIV_W-1:0] cnt_r;
  logic pre_en;

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  assign pre_en = div_by_four ? (pre_r == PRE_LAST) : 1'b1;

  always_ff @(posedge clk) begin
    if (sys_rst || !div_by_four) begin
      pre_r <= 2'h0;
    end else begin
      pre_r <= pre_r + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Divisor counter, clocked only by prescaler enables
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r <= '0;
      tick16 <= 1'b0;
      baud_clk <= 1'b0;
    end else begin
      tick16 <= 1'b0;
      if (pre_en) begin
        if (cnt_r + 1'b1 >= divisor) begin
          cnt_r <= '0;
          tick16 <= 1'b1;
          baud_clk <= ~baud_clk;
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end

endmodule // umcl_baud_gen
`default_nettype wire

// ---- core/umcl_top.sv ----
// Two serial channels with modem control, loopback, infrared and flow control.
// Assumes an Avalon-MM master with word addressing and modem pins active low.
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module umcl_top
  import umcl_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic [1:0] serial_rx_pin,
  output wire logic [1:0] serial_tx_pin,
  input wire umcl_mstat_t [1:0] modem_in_n,
  output wire umcl_mctl_t [1:0] modem_out_n,
  output wire logic [1:0] aux_pin
);

  // Applies byte enables to a register image.
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // One wait state per access; read side effects act at the capture edge, so no store is lost.
  logic acc_rd;
  logic acc_wr;
  logic [31:0] ch_rdata [UMCL_CHANNELS];
  logic [1:0] ch_irq;

  assign acc_rd = avs_read && avs_waitrequest;
  assign acc_wr = avs_write && !avs_waitrequest;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(avs_waitrequest && (avs_read || avs_write));
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0;
    end else if (acc_rd) begin
      avs_readdata <= ch_rdata[avs_address[3]];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |ch_irq;
    end
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  generate
    for (genvar g = 0; g < UMCL_CHANNELS; g++) begin : g_ch
      logic sel;
      logic wr;
      logic rd;
      logic [31:0] wmerge;
      logic [7:0] mlc_r;
      logic [15:0] div_r;
      logic flow_en_r;
      logic [7:0] xon_r;
      logic [7:0] xoff_r;
      umcl_afs_t afs_r;
      logic [2:0] ist_r;
      logic [2:0] imk_r;
      logic loop;
      logic tick;
      logic baud_clk;
      logic [7:0] thr_r;
      logic thr_valid_r;
      logic [7:0] tsh_r;
      umcl_shift_t tst_r;
      logic [3:0] tsub_r;
      logic [2:0] tbit_r;
      logic tx_bit;
      logic tx_load;
      logic halted_r;
      logic txp_r;
      logic rx_s1_r;
      logic rx_s2_r;
      logic [3:0] ir_hold_r;
      logic rx_dec;
      logic rx_src;
      umcl_shift_t rst_r;
      logic [3:0] rsub_r;
      logic [2:0] rbit_r;
      logic [7:0] rsh_r;
      logic rx_done;
      logic is_xon;
      logic is_xoff;
      logic rx_store;
      logic [7:0] rbr_r;
      logic rx_valid_r;
      umcl_mstat_t ms_s1_r;
      umcl_mstat_t ms_s2_r;
      umcl_mstat_t ms_cur;
      umcl_mstat_t ms_prev_r;
      umcl_mstat_t ms_delta_r;
      logic ms_change;
      umcl_mctl_t mout_r;
      logic aux_r;
      logic [2:0] ev;

      assign sel = (avs_address[3] == 1'(g));
      assign wr = acc_wr && sel;
      assign rd = acc_rd && sel;
      assign loop = mlc_r[MLC_LOOP];

      // -------------------------------------------------------------
      // Control registers
      // -------------------------------------------------------------
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          mlc_r <= MLC_RESET;
          div_r <= DIV_RESET;
          flow_en_r <= 1'b0;
          xon_r <= XON_RESET;
          xoff_r <= XOFF_RESET;
          afs_r <= AFS_AUX_OUTPUT_TWO;
          imk_r <= IRQ_RESET;
        end else if (wr) begin
          case (avs_address[2:0])
            REG_MLC: mlc_r <= wmerge[7:0];
            REG_DIV: div_r <= wmerge[15:0];
            REG_FLOW: begin
              flow_en_r <= wmerge[0];
              xon_r <= wmerge[15:8];
              xoff_r <= wmerge[23:16];
            end
            REG_AFS: afs_r <= umcl_afs_t'(wmerge[1:0]);
            REG_IMK: imk_r <= wmerge[2:0];
            default: ;
          endcase
        end
      end

      always_comb begin
        ch_rdata[g] = 32'h0;
        wmerge = 32'h0;
        case (avs_address[2:0])
          REG_DATA: ch_rdata[g] = {22'h0, thr_valid_r, rx_valid_r, rbr_r};
          REG_MLC: ch_rdata[g] = {24'h0, mlc_r};
          REG_MSR: ch_rdata[g] = {24'h0, ms_cur, ms_delta_r};
          REG_DIV: ch_rdata[g] = {16'h0, div_r};
          REG_FLOW: ch_rdata[g] = {8'h0, xoff_r, xon_r, 7'h0, flow_en_r};
          REG_AFS: ch_rdata[g] = {30'h0, afs_r};
          REG_IST: ch_rdata[g] = {29'h0, ist_r};
          REG_IMK: ch_rdata[g] = {29'h0, imk_r};
          default: ch_rdata[g] = 32'h0;
        endcase
        wmerge = be_merge(ch_rdata[g], avs_writedata, avs_byteenable);
      end

      umcl_baud_gen #(
        .DIV_W(16)
      ) u_baud (
        .clk(clk),
        .sys_rst(sys_rst),
        .div_by_four(mlc_r[MLC_DIV4]),
        .divisor(div_r),
        .tick16(tick),
        .baud_clk(baud_clk)
      );

      // -------------------------------------------------------------
      // Transmitter
      // -------------------------------------------------------------
      assign tx_load = tick && (tst_r == SH_IDLE) && thr_valid_r && !halted_r;
      assign tx_bit = (tst_r == SH_START) ? 1'b0 :
                      (tst_r == SH_DATA) ? tsh_r[0] : 1'b1;

      always_ff @(posedge clk) begin
        if (sys_rst) begin
          thr_valid_r <= 1'b0;
          thr_r <= 8'h0;
        end else if (wr && avs_address[2:0] == REG_DATA && avs_byteenable[0]) begin
          thr_valid_r <= 1'b1;
          thr_r <= avs_writedata[7:0];
        end else if (tx_load) begin
          thr_valid_r <= 1'b0;
        end
      end

      always_ff @(posedge clk) begin
        if (sys_rst) begin
          tst_r <= SH_IDLE;
          tsh_r <= 8'h0;
          tsub_r <= 4'h0;
          tbit_r <= 3'h0;
        end else if (tick) begin
          tsub_r <= tsub_r + 4'h1;
          case (tst_r)
            SH_IDLE: begin
              tsub_r <= 4'h0;
              if (tx_load) begin
                tsh_r <= thr_r;
                tst_r <= SH_START;
              end
            end
            SH_START: begin
              if (tsub_r == OVERSAMPLE_LAST) begin
                tst_r <= SH_DATA;
                tbit_r <= 3'h0;
              end
            end
            SH_DATA: begin
              if (tsub_r == OVERSAMPLE_LAST) begin
                tsh_r <= {1'b1, tsh_r[7:1]};
                tbit_r <= tbit_r + 3'h1;
                if (tbit_r == 3'h7) begin
                  tst_r <= SH_STOP;
                end
              end
            end
            SH_STOP: begin
              if (tsub_r == OVERSAMPLE_LAST) begin
                tst_r <= SH_IDLE;
              end
            end
            default: tst_r <= SH_IDLE;
          endcase
        end
      end

      // Infrared sends a short high pulse per zero bit and idles low.
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          txp_r <= 1'b1;
        end else if (loop) begin
          txp_r <= 1'b1;
        end else if (mlc_r[MLC_IR]) begin
          txp_r <= !tx_bit && (tsub_r < IR_PULSE_TICKS);
        end else begin
          txp_r <= tx_bit;
        end
      end
      assign serial_tx_pin[g] = txp_r;

      // -------------------------------------------------------------
      // Receiver input path
      // -------------------------------------------------------------
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          rx_s1_r <= 1'b1;
          rx_s2_r <= 1'b1;
        end else begin
          rx_s1_r <= serial_rx_pin[g];
          rx_s2_r <= rx_s1_r;
        end
      end

      // A received infrared pulse is stretched to a full low bit time.
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          ir_hold_r <= 4'h0;
        end else if (rx_s2_r) begin
          ir_hold_r <= OVERSAMPLE_LAST;
        end else if (tick && ir_hold_r != 4'h0) begin
          ir_hold_r <= ir_hold_r - 4'h1;
        end
      end

      assign rx_dec = mlc_r[MLC_IR] ? !(rx_s2_r || ir_hold_r != 4'h0) : rx_s2_r;
      assign rx_src = loop ? tx_bit : rx_dec;

      always_ff @(posedge clk) begin
        if (sys_rst) begin
          rst_r <= SH_IDLE;
          rsub_r <= 4'h0;
          rbit_r <= 3'h0;
          rsh_r <= 8'h0;
          rx_done <= 1'b0;
        end else begin
          rx_done <= 1'b0;
          if (tick) begin
            rsub_r <= rsub_r + 4'h1;
            case (rst_r)
              SH_IDLE: begin
                rsub_r <= 4'h0;
                if (!rx_src) begin
                  rst_r <= SH_START;
                end
              end
              SH_START: begin
                if (rsub_r == MID_BIT) begin
                  rsub_r <= 4'h0;
                  rbit_r <= 3'h0;
                  rst_r <= rx_src ? SH_IDLE : SH_DATA;
                end
              end
              SH_DATA: begin
                if (rsub_r == OVERSAMPLE_LAST) begin
                  rsh_r <= {rx_src, rsh_r[7:1]};
                  rbit_r <= rbit_r + 3'h1;
                  if (rbit_r == 3'h7) begin
                    rst_r <= SH_STOP;
                  end
                end
              end
              SH_STOP: begin
                if (rsub_r == OVERSAMPLE_LAST) begin
                  rst_r <= SH_IDLE;
                  rx_done <= rx_src;
                end
              end
              default: rst_r <= SH_IDLE;
            endcase
          end
        end
      end

      // -------------------------------------------------------------
      // Software flow control and receive buffer
      // -------------------------------------------------------------
      assign is_xon = flow_en_r && (rsh_r == xon_r);
      assign is_xoff = flow_en_r && (rsh_r == xoff_r);
      assign rx_store = rx_done && !is_xon && !is_xoff;

      always_ff @(posedge clk) begin
        if (sys_rst || !flow_en_r) begin
          halted_r <= 1'b0;
        end else if (rx_done) begin
          if (is_xoff) begin
            halted_r <= 1'b1;
          end else if (is_xon || mlc_r[MLC_XANY]) begin
            halted_r <= 1'b0;
          end
        end
      end

      // A new character wins over a read that pops the old one.
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          rbr_r <= 8'h0;
          rx_valid_r <= 1'b0;
        end else if (rx_store) begin
          rbr_r <= rsh_r;
          rx_valid_r <= 1'b1;
        end else if (rd && avs_address[2:0] == REG_DATA) begin
          rx_valid_r <= 1'b0;
        end
      end

      // -------------------------------------------------------------
      // Modem lines
      // -------------------------------------------------------------
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          ms_s1_r <= 4'hf;
          ms_s2_r <= 4'hf;
        end else begin
          ms_s1_r <= modem_in_n[g];
          ms_s2_r <= ms_s1_r;
        end
      end

      always_comb begin
        if (loop) begin
          ms_cur.dcd = mlc_r[MLC_AUX_OUTPUT_TWO];
          ms_cur.ri = mlc_r[MLC_AUX_OUTPUT_ONE];
          ms_cur.dsr = mlc_r[MLC_DTR];
          ms_cur.cts = mlc_r[MLC_RTS];
        end else begin
          ms_cur = ~ms_s2_r;
        end
      end

      assign ms_change = (ms_cur != ms_prev_r);

      always_ff @(posedge clk) begin
        if (sys_rst) begin
          ms_prev_r <= 4'h0;
          ms_delta_r <= 4'h0;
        end else begin
          ms_prev_r <= ms_cur;
          if (rd && avs_address[2:0] == REG_MSR) begin
            ms_delta_r <= ms_cur ^ ms_prev_r;
          end else begin
            ms_delta_r <= ms_delta_r | (ms_cur ^ ms_prev_r);
          end
        end
      end

      always_ff @(posedge clk) begin
        if (sys_rst) begin
          mout_r <= 2'h3;
        end else if (loop) begin
          mout_r <= 2'h3;
        end else begin
          mout_r.rts <= !mlc_r[MLC_RTS];
          mout_r.dtr <= !mlc_r[MLC_DTR];
        end
      end
      assign modem_out_n[g] = mout_r;

      // Receive DMA ready is active low: low while a character waits.
      always_ff @(posedge clk) begin
        if (sys_rst || loop) begin
          aux_r <= 1'b1;
        end else begin
          case (afs_r)
            AFS_AUX_OUTPUT_TWO: aux_r <= !mlc_r[MLC_AUX_OUTPUT_TWO];
            AFS_BAUD: aux_r <= baud_clk;
            AFS_RXRDY: aux_r <= !rx_valid_r;
            default: aux_r <= !mlc_r[MLC_AUX_OUTPUT_TWO];
          endcase
        end
      end
      assign aux_pin[g] = aux_r;

      // -------------------------------------------------------------
      // Interrupt status, write one to clear, set wins
      // -------------------------------------------------------------
      assign ev = {ms_change, tx_load, rx_store};

      always_ff @(posedge clk) begin
        if (sys_rst) begin
          ist_r <= IRQ_RESET;
        end else if (wr && avs_address[2:0] == REG_IST && avs_byteenable[0]) begin
          ist_r <= (ist_r & ~avs_writedata[2:0]) | ev;
        end else begin
          ist_r <= ist_r | ev;
        end
      end

      assign ch_irq[g] = |(ist_r & imk_r);
    end
  endgenerate

endmodule // umcl_top
`default_nettype wire

// ---- sim/umcl_chk.sv ----
// Checker for the modem control block: bus handshake, reset values and pin rules.
// Assumes control writes use byte lane 0 and the divisor stays at its reset value.
`timescale 1ns/1ns
`default_nettype none
module umcl_chk
  import umcl_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic irq,
  input wire logic [1:0] serial_tx_pin,
  input wire umcl_mctl_t [1:0] modem_out_n,
  input wire logic [1:0] aux_pin
);
  // ----------------------------------------
  // Register shadows
  // ----------------------------------------
  logic [7:0] m_r [2];
  logic [1:0] a_r [2];
  logic [2:0] age_r [2];
  // Pins are judged only once a control write has had time to reach them.
  always_ff @(posedge clk) begin
    for (int c = 0; c < 2; c++) begin
      if (sys_rst) begin
        m_r[c] <= 8'h00;
        a_r[c] <= 2'h0;
        age_r[c] <= 3'h0;
      end else if (avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address[3] == c[0] &&
                   (avs_address[2:0] == REG_MLC || avs_address[2:0] == REG_AFS)) begin
        if (avs_address[2:0] == REG_MLC) m_r[c] <= avs_writedata[7:0];
        else a_r[c] <= avs_writedata[1:0];
        age_r[c] <= 3'h0;
      end else if (age_r[c] != 3'h7) begin
        age_r[c] <= age_r[c] + 3'h1;
      end
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ans;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  AST_BUS_ANSWER: assert property (s_req |=> s_ans)
    else $error("bus answer not one cycle after the request");
  AST_BUS_IDLE: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("waitrequest low without a request");
  AST_RDATA_HOLD: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data changed without a read");
  AST_RESET_OUT: assert property (disable iff (1'b0) sys_rst |=> avs_waitrequest && !irq &&
    serial_tx_pin == 2'b11 && modem_out_n == 4'hf && aux_pin == 2'b11)
    else $error("outputs not at reset level");
  for (genvar c = 0; c < 2; c++) begin : g_ch
    wire logic ok_w = age_r[c] == 3'h7 && !avs_write;
    wire logic lp_w = m_r[c][MLC_LOOP];
    AST_MODEM_OUT: assert property (ok_w |-> modem_out_n[c] == (lp_w ? 2'b11 : ~m_r[c][1:0]))
      else $error("modem outputs do not follow the control bits");
    AST_AUX_AUX_OUTPUT_TWO: assert property (ok_w && (a_r[c] == AFS_AUX_OUTPUT_TWO || lp_w) |->
      aux_pin[c] == (lp_w || !m_r[c][MLC_AUX_OUTPUT_TWO]))
      else $error("aux pin does not follow control bit 3");
    AST_TX_MARK: assert property (ok_w && lp_w |-> serial_tx_pin[c])
      else $error("serial output not marking in loopback");
    AST_BAUD_DIV1: assert property (ok_w && a_r[c] == AFS_BAUD && !lp_w && !m_r[c][MLC_DIV4] |=>
      aux_pin[c] != $past(aux_pin[c]))
      else $error("baud clock not toggling every clock");
  end
endmodule // umcl_chk
bind umcl_top umcl_chk i_chk (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
  .serial_tx_pin(serial_tx_pin), .modem_out_n(modem_out_n), .aux_pin(aux_pin));
`default_nettype wire

// ---- sim/umcl_mdm.sv ----
// Modem side model: drives the serial inputs and modem status pins, decodes the serial outputs.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module umcl_mdm
  import umcl_pkg::*;
(
  input wire logic clk,
  input wire logic [1:0] tx,
  output var logic [1:0] rx,
  output var umcl_mstat_t [1:0] st_n
);
  // ----------------------------------------
  // Line tasks
  // ----------------------------------------
  initial begin
    rx = 2'b11;
    st_n = '1;
  end
  task automatic send(input int c, input logic [7:0] b, input int bt);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx[c] <= f[i];
      repeat (bt) @(posedge clk);
    end
  endtask
  // Sampling mid-bit tolerates a start edge seen one cycle late.
  task automatic recv(input int c, input int bt, output logic [7:0] b);
    int n;
    n = 0;
    while (tx[c] !== 1'b0 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    repeat (bt / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bt) @(posedge clk);
      b[i] = tx[c];
    end
  endtask
endmodule // umcl_mdm
`default_nettype wire

// ---- sim/tb.sv ----
// Testbench: register tasks on the Avalon port, line traffic through the modem model.
// Assumes divisor 1, so one bit lasts 16 clocks, or 64 with divide by four.
`timescale 1ns/1ns
`default_nettype none
module tb
  import umcl_pkg::*;
;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata;
  logic wait_w;
  logic irq;
  logic [31:0] rdat;
  logic [7:0] rx_b;
  logic [1:0] rx;
  wire logic [1:0] tx;
  umcl_mstat_t [1:0] st_n;
  wire umcl_mctl_t [1:0] mo_n;
  wire logic [1:0] aux;
  logic [7:0] lb [4] = '{8'h20, 8'h10, 8'h40, 8'h80};
  int error_cnt = 0;
  int n_checks = 0;
  umcl_top i_dut (.clk(clk), .sys_rst(sys_rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(4'h1), .avs_readdata(rdata), .avs_waitrequest(wait_w), .irq(irq),
    .serial_rx_pin(rx), .serial_tx_pin(tx), .modem_in_n(st_n), .modem_out_n(mo_n), .aux_pin(aux));
  umcl_mdm i_mdm (.clk(clk), .tx(tx), .rx(rx), .st_n(st_n));
  initial begin
    forever #20 clk = ~clk;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    do begin
      @(posedge clk);
      n++;
    end while (wait_w !== 1'b0 && n < 20);
    if (n >= 20) check(32'h1, 32'h0);
    rdat = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_irq(input logic v);
    int n;
    n = 0;
    while (irq !== v && n < 2000) begin
      @(posedge clk);
      n++;
    end
    check(32'(irq), 32'(v));
  endtask
  task automatic end_sim;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    acc(1'b0, 4'h1, 0); check(rdat, 32'h0);
    i_mdm.st_n[1] <= 4'b1010;
    acc(1'b1, 4'h1, 32'h0b);
    repeat (3) @(posedge clk);
    check(32'({aux[0], mo_n[1], mo_n[0]}), 32'h0c);
    acc(1'b0, 4'ha, 0); check(rdat & 32'hf0, 32'h50);
    $display("test pins done");
    // Pins are driven active and the serial input held low to show that loopback ignores them.
    i_mdm.st_n[0] <= '0;
    i_mdm.rx[0] <= 1'b0;
    acc(1'b1, 4'h1, 32'h18);
    repeat (3) @(posedge clk);
    check(32'({tx[0], aux[0], mo_n[0]}), 32'h0f);
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, 4'h1, 32'h10 | (32'h1 << i));
      repeat (3) @(posedge clk);
      acc(1'b0, 4'h2, 0); check(rdat & 32'hf0, 32'(lb[i]));
    end
    acc(1'b1, 4'h7, 32'h4);
    acc(1'b1, 4'h6, 32'h7);
    wait_irq(1'b0);
    acc(1'b1, 4'h1, 32'h11);
    wait_irq(1'b1);
    acc(1'b1, 4'h6, 32'h4);
    wait_irq(1'b0);
    $display("test loop status done");
    acc(1'b1, 4'h7, 32'h1);
    acc(1'b1, 4'h6, 32'h7);
    acc(1'b1, 4'h0, 32'ha5);
    wait_irq(1'b1);
    acc(1'b0, 4'h6, 0); check(rdat & 32'h7, 32'h3);
    acc(1'b0, 4'h0, 0); check(rdat & 32'h1ff, 32'h1a5);
    acc(1'b1, 4'h6, 32'h7);
    wait_irq(1'b0);
    acc(1'b1, 4'h7, 32'h0);
    acc(1'b1, 4'h0, 32'h5a);
    repeat (300) @(posedge clk);
    check(32'(irq), 32'h0);
    acc(1'b0, 4'h0, 0); check(rdat & 32'h1ff, 32'h15a);
    $display("test loop data done");
    i_mdm.rx[0] <= 1'b1;
    acc(1'b1, 4'h1, 32'h00);
    check(32'(tx[0]), 32'h1);
    acc(1'b1, 4'h0, 32'h96);
    i_mdm.recv(0, 16, rx_b); check(32'(rx_b), 32'h96);
    acc(1'b1, 4'h5, 32'h1);
    repeat (20) @(posedge clk);
    acc(1'b1, 4'h5, 32'h0);
    acc(1'b1, 4'h1, 32'h40);
    repeat (5) @(posedge clk);
    check(32'(tx[0]), 32'h0);
    $display("test transmit done");
    for (int i = 0; i < 2; i++) begin
      acc(1'b1, 4'h9, 32'(i << 7));
      i_mdm.send(1, 8'h3c + 8'(i), 16 << (2 * i));
      repeat (40) @(posedge clk);
      acc(1'b0, 4'h8, 0); check(rdat & 32'h1ff, 32'h13c + 32'(i));
    end
    $display("test prescaler done");
    acc(1'b1, 4'hc, 32'h1);
    acc(1'b1, 4'h9, 32'h20);
    i_mdm.send(1, 8'h13, 16);
    repeat (40) @(posedge clk);
    acc(1'b0, 4'h8, 0); check(rdat & 32'h100, 32'h0);
    acc(1'b1, 4'h8, 32'h55);
    repeat (40) @(posedge clk);
    check(32'(tx[1]), 32'h1);
    fork
      i_mdm.send(1, 8'h41, 16);
      i_mdm.recv(1, 16, rx_b);
    join
    check(32'(rx_b), 32'h55);
    acc(1'b1, 4'hd, 32'h2);
    repeat (3) @(posedge clk);
    check(32'(aux[1]), 32'h0);
    acc(1'b0, 4'h8, 0); check(rdat & 32'h1ff, 32'h141);
    repeat (3) @(posedge clk);
    check(32'(aux[1]), 32'h1);
    $display("test resume done");
    end_sim();
  end
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
endmodule // tb
`default_nettype wire
